// file: reset_startup_pkg.sv
// Constants and carrier types for the reset and start-up sequencer
`default_nettype none
package reset_startup_pkg;

    // Clock and time base
    localparam int CLK_PERIOD_NS          = 40;
    localparam int TICK_TIME_NS           = 1000;
    localparam int TICK_CYCLES            = TICK_TIME_NS / CLK_PERIOD_NS;
    localparam int TICK_CNT_W             = 5;

    // Power-up delay: 64 ms counted in slow ticks
    localparam int POWERUP_TIME_MS        = 64;
    localparam int POWERUP_TICKS          = POWERUP_TIME_MS * 1000000 / TICK_TIME_NS;
    localparam int POWERUP_CNT_W          = 20;

    // Brown-out glitch filter: least time, rounded up to cycles
    localparam int BROWNOUT_FILTER_TIME_NS = 2000;
    localparam int FILTER_CYCLES          =
        (BROWNOUT_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILTER_CNT_W           = 8;

    // Input synchroniser depth
    localparam int SYNC_STAGES            = 3;

    // Register port
    localparam int ADDR_W                 = 4;
    localparam int DATA_W                 = 8;
    localparam logic [ADDR_W-1:0] CONTROL_OFFSET = 4'h0;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET  = 4'h1;

    // Field positions
    localparam int READY_BIT              = 0;
    localparam int SW_ENABLE_BIT          = 7;
    localparam int ST_CORE_RESET_BIT      = 0;
    localparam int ST_POR_BIT             = 1;
    localparam int ST_BOR_BIT             = 2;
    localparam int ST_TIMER_BIT           = 3;

    // Values after reset
    localparam logic SW_ENABLE_RESET      = 1'b1;

    // Brown-out mode field encodings
    localparam logic [1:0] MODE_ALWAYS_ON = 2'h3;
    localparam logic [1:0] MODE_AWAKE_ON  = 2'h2;
    localparam logic [1:0] MODE_SOFTWARE  = 2'h1;
    localparam logic [1:0] MODE_OFF       = 2'h0;

    // Analogue comparator outputs
    typedef struct packed {
        logic supply_ok;
        logic below_threshold;
        logic detector_ready;
    } analog_in_type;

    // Configuration word fields
    typedef struct packed {
        logic [1:0] brownout_mode_sel;
        logic       powerup_delay_enable_n;
        logic       brownout_level_sel;
    } config_type;

    localparam int SYNC_W = $bits(analog_in_type) + $bits(config_type);

    typedef enum {
        SEQ_POR,
        SEQ_WAIT_BOR,
        SEQ_TIMER,
        SEQ_RUN,
        SEQ_BOR_HOLD
    } seq_state_type;

endpackage
`default_nettype wire

// file: reset_startup_sequencer.sv
// Device reset and start-up sequencer: power-on, brown-out and power-up delay
//
// Summary of operation
// R1 - Supply reported insufficient by power-on detector holds whole device in reset.
// R2 - Power-up delay timer gives nominal 64 ms after power-on or brown-out reset.
// R3 - Device stays in reset throughout the running power-up delay.
// R4 - Power-up delay is active only when its enable bit is zero.
// R5 - Power-up delay starts only after power-on and brown-out resets are released.
// R6 - Mode field: 11 on, 10 off in Sleep, 01 software, 00 off.
// R7 - Brown-out trips only when supply stays low longer than the filter time.
// R8 - Mode 11 start-up waits ready and supply; Sleep protected; wake not delayed.
// R9 - Mode 10 detector off in Sleep; start-up and wake wait for ready.
// R10 - Mode 01 software bit switches detector; start-up waits for nothing.
// R11 - Software mode protection starts when ready; Sleep does not change it.
// R12 - Detector readiness is a readable bit in the brown-out control register.
// R13 - Forced-on modes set ready before the core leaves reset.
// R14 - One configuration bit selects the brown-out trip level.
// R15 - Core reset held while any reset source or delay is active.
// R16 - Software enable is ignored outside software-controlled mode.
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module reset_startup_sequencer #(
    parameter int POWERUP_DELAY_TICKS = reset_startup_pkg::POWERUP_TICKS
) (
    input  wire logic                                SYS_CLK,
    input  wire logic                                RST,
    input  wire reset_startup_pkg::analog_in_type    ANALOG_IN,
    input  wire reset_startup_pkg::config_type       CONFIG_IN,
    input  wire logic                                SLEEP,
    input  wire logic                                WAKE_REQ,
    input  wire logic [reset_startup_pkg::ADDR_W-1:0] ADDR,
    input  wire logic [reset_startup_pkg::DATA_W-1:0] WDATA,
    input  wire logic                                WR,
    input  wire logic                                RD,
    output var  logic [reset_startup_pkg::DATA_W-1:0] RDATA,
    output var  logic                                CORE_RESET,
    output var  logic                                BROWNOUT_ENABLE,
    output var  logic                                BROWNOUT_LEVEL,
    output var  logic                                BROWNOUT_RESET,
    output var  logic                                WAKE_GRANT
);
    import reset_startup_pkg::*;

    logic [SYNC_W-1:0]       raw_in;
    logic [SYNC_W-1:0]       sync1_reg;
    logic [SYNC_W-1:0]       sync2_reg;
    logic [SYNC_W-1:0]       sync3_reg;
    logic [SYNC_W-1:0]       clean_reg;
    analog_in_type           analog_s;
    config_type              config_s;

    logic                    sw_enable_reg;
    logic                    detector_on;
    logic                    ready_now;
    logic                    protect_on;
    logic                    forced_mode;
    logic                    bor_trip_reg;
    logic [FILTER_CNT_W-1:0] filter_cnt_reg;
    logic [TICK_CNT_W-1:0]   tick_cnt_reg;
    logic                    tick;
    logic [POWERUP_CNT_W-1:0] delay_cnt_reg;
    seq_state_type           state_reg;
    seq_state_type           state_next;
    logic                    delay_run;

    assign raw_in = {ANALOG_IN, CONFIG_IN};

    // Three-stage synchronisers; a change is taken once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi = gi + 1) begin : g_sync
            always_ff @(posedge SYS_CLK) begin
                sync1_reg[gi] <= raw_in[gi];
                sync2_reg[gi] <= sync1_reg[gi];
                sync3_reg[gi] <= sync2_reg[gi];
                if (sync2_reg[gi] == sync3_reg[gi]) begin
                    clean_reg[gi] <= sync3_reg[gi];
                end
            end
        end
    endgenerate

    assign analog_s = clean_reg[SYNC_W-1:$bits(config_type)];
    assign config_s = clean_reg[$bits(config_type)-1:0];

    // Detector power per mode; software bit only counts in software mode
    always_comb begin
        case (config_s.brownout_mode_sel)
            MODE_ALWAYS_ON: detector_on = 1'b1;                    // R6 R8
            MODE_AWAKE_ON:  detector_on = !SLEEP || WAKE_REQ;      // R6 R9
            MODE_SOFTWARE:  detector_on = sw_enable_reg;           // R6 R10 R11 R16
            default:        detector_on = 1'b0;                    // R6
        endcase
    end

    // Modes where the field itself forces the detector on
    assign forced_mode = config_s.brownout_mode_sel[1];

    // Ready only while powered; protection follows readiness
    assign ready_now  = detector_on && analog_s.detector_ready;
    assign protect_on = ready_now;                                 // R11

    // Glitch filter: trip only after the low level outlasts the filter time
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            filter_cnt_reg <= '0;
            bor_trip_reg   <= 1'b0;
        end else if (!protect_on || !analog_s.below_threshold) begin
            filter_cnt_reg <= '0;                                  // R7
            bor_trip_reg   <= 1'b0;
        end else if (filter_cnt_reg == FILTER_CNT_W'(FILTER_CYCLES)) begin
            bor_trip_reg   <= 1'b1;                                // R7
        end else begin
            filter_cnt_reg <= filter_cnt_reg + 1'b1;
        end
    end

    // Slow time base for the power-up delay
    always_ff @(posedge SYS_CLK) begin
        if (RST || tick) begin
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
        end
    end

    assign tick = (tick_cnt_reg == TICK_CNT_W'(TICK_CYCLES - 1));

    // Sequencer: reset sources, readiness wait, power-up delay, run
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SEQ_POR: begin
                if (analog_s.supply_ok) begin
                    state_next = SEQ_WAIT_BOR;                     // R1
                end
            end
            SEQ_WAIT_BOR: begin
                if (!analog_s.supply_ok) begin
                    state_next = SEQ_POR;
                end else if (!forced_mode) begin
                    state_next = SEQ_TIMER;                        // R10
                end else if (ready_now && !analog_s.below_threshold) begin
                    state_next = SEQ_TIMER;                        // R8 R9 R13
                end
            end
            SEQ_TIMER: begin
                if (!analog_s.supply_ok) begin
                    state_next = SEQ_POR;
                end else if (bor_trip_reg) begin
                    state_next = SEQ_BOR_HOLD;
                end else if (!delay_run) begin
                    state_next = SEQ_RUN;                          // R3
                end
            end
            SEQ_RUN: begin
                if (!analog_s.supply_ok) begin
                    state_next = SEQ_POR;                          // R1
                end else if (bor_trip_reg) begin
                    state_next = SEQ_BOR_HOLD;
                end
            end
            SEQ_BOR_HOLD: begin
                if (!analog_s.supply_ok) begin
                    state_next = SEQ_POR;
                end else if (!bor_trip_reg) begin
                    state_next = SEQ_WAIT_BOR;                     // R5
                end
            end
            default: begin
                state_next = SEQ_POR;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            state_reg <= SEQ_POR;
        end else begin
            state_reg <= state_next;
        end
    end

    // Delay runs while the count is short of its end, only when enabled (active low)
    assign delay_run = !config_s.powerup_delay_enable_n &&          // R4
                       (delay_cnt_reg != POWERUP_CNT_W'(POWERUP_DELAY_TICKS));

    // Power-up delay counter, cleared in every state before it
    always_ff @(posedge SYS_CLK) begin
        if (RST || state_reg != SEQ_TIMER) begin
            delay_cnt_reg <= '0;                                   // R5
        end else if (tick && delay_run) begin
            delay_cnt_reg <= delay_cnt_reg + 1'b1;                 // R2
        end
    end

    // Software enable bit of the control register
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            sw_enable_reg <= SW_ENABLE_RESET;
        end else if (WR && ADDR == CONTROL_OFFSET) begin
            sw_enable_reg <= WDATA[SW_ENABLE_BIT];
        end
    end

    // Read data, valid in the cycle after the strobe only
    always_ff @(posedge SYS_CLK) begin
        if (RST || !RD) begin
            RDATA <= '0;
        end else begin
            RDATA <= '0;
            case (ADDR)
                CONTROL_OFFSET: begin
                    RDATA[SW_ENABLE_BIT] <= sw_enable_reg;
                    RDATA[READY_BIT]     <= ready_now;             // R12
                end
                STATUS_OFFSET: begin
                    RDATA[ST_CORE_RESET_BIT] <= CORE_RESET;
                    RDATA[ST_POR_BIT]        <= !analog_s.supply_ok;
                    RDATA[ST_BOR_BIT]        <= bor_trip_reg;
                    RDATA[ST_TIMER_BIT]      <= (state_reg == SEQ_TIMER);
                end
                default: begin
                    RDATA <= '0;
                end
            endcase
        end
    end

    // Core reset: high in every state except run
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            CORE_RESET <= 1'b1;
        end else begin
            CORE_RESET <= (state_next != SEQ_RUN);                 // R1 R3 R15
        end
    end

    // Analogue controls and brown-out status
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            BROWNOUT_ENABLE <= 1'b0;
            BROWNOUT_LEVEL  <= 1'b0;
            BROWNOUT_RESET  <= 1'b0;
        end else begin
            BROWNOUT_ENABLE <= detector_on;                        // R6
            BROWNOUT_LEVEL  <= config_s.brownout_level_sel;        // R14
            BROWNOUT_RESET  <= bor_trip_reg;
        end
    end

    // Wake grant: mode 10 waits for ready, other modes wake at once
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            WAKE_GRANT <= 1'b0;
        end else if (!WAKE_REQ || state_reg != SEQ_RUN) begin
            WAKE_GRANT <= 1'b0;
        end else if (config_s.brownout_mode_sel == MODE_AWAKE_ON) begin
            WAKE_GRANT <= ready_now;                               // R9
        end else begin
            WAKE_GRANT <= 1'b1;                                    // R8 R11
        end
    end

endmodule
`default_nettype wire

// file: core_model.sv
// Behavioural core model: enters Sleep on command, then asks to wake
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input  wire logic clk,
    input  wire logic core_reset,
    input  wire logic wake_grant,
    input  wire logic sleep_cmd,
    output var  logic sleep,
    output var  logic wake_req
);
    // Sleep is left only once the wake grant comes back; reset clears both
    always_ff @(posedge clk) begin
        if (core_reset) begin
            sleep    <= 1'b0;
            wake_req <= 1'b0;
        end else if (sleep_cmd) begin
            sleep <= 1'b1;
        end else if (sleep && !wake_req) begin
            wake_req <= 1'b1;
        end else if (wake_grant) begin
            sleep    <= 1'b0;
            wake_req <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: reset_startup_chk.sv
// Port checker for the reset and start-up sequencer
`timescale 1ns/1ps
`default_nettype none
module reset_startup_chk #(
    parameter int POWERUP_DELAY_TICKS = 4
) (
    input wire logic                                 SYS_CLK,
    input wire logic                                 RST,
    input wire reset_startup_pkg::analog_in_type     ANALOG_IN,
    input wire reset_startup_pkg::config_type        CONFIG_IN,
    input wire logic                                 WAKE_REQ,
    input wire logic [reset_startup_pkg::ADDR_W-1:0] ADDR,
    input wire logic                                 RD,
    input wire logic [reset_startup_pkg::DATA_W-1:0] RDATA,
    input wire logic                                 CORE_RESET,
    input wire logic                                 BROWNOUT_ENABLE,
    input wire logic                                 BROWNOUT_LEVEL,
    input wire logic                                 BROWNOUT_RESET,
    input wire logic                                 WAKE_GRANT,
    input wire logic                                 SLEEP
);
    import reset_startup_pkg::*;
    logic [7:0]  up_cnt;
    logic [7:0]  low_cnt;
    logic [19:0] ok_cnt;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    // Saturating run lengths: since reset, raw dip, raw good supply
    always_ff @(posedge SYS_CLK) begin
        up_cnt  <= RST ? 8'h00 : up_cnt + {7'h00, up_cnt != 8'hff};
        low_cnt <= (RST || !ANALOG_IN.below_threshold) ? 8'h00 : low_cnt + {7'h00, low_cnt != 8'hff};
        ok_cnt  <= (RST || !ANALOG_IN.supply_ok) ? 20'h00000 : ok_cnt + {19'h00000, ok_cnt != 20'hfffff};
    end
    por_hold_a: assert property (!ANALOG_IN.supply_ok [*6] |-> CORE_RESET)
        else $error("core released without supply");
    delay_len_a: assert property ($fell(CORE_RESET) && !CONFIG_IN.powerup_delay_enable_n
        |-> ok_cnt >= (POWERUP_DELAY_TICKS - 1) * TICK_CYCLES) else $error("start-up delay too short");
    off_mode_a: assert property ((CONFIG_IN.brownout_mode_sel == MODE_OFF) [*7] |-> !BROWNOUT_ENABLE)
        else $error("detector on in off mode");
    on_mode_a: assert property ((CONFIG_IN.brownout_mode_sel == MODE_ALWAYS_ON && ANALOG_IN.supply_ok) [*7]
        |-> BROWNOUT_ENABLE) else $error("detector off in always-on mode");
    sleep_off_a: assert property ((CONFIG_IN.brownout_mode_sel == MODE_AWAKE_ON && SLEEP && !WAKE_REQ) [*7]
        |-> !BROWNOUT_ENABLE) else $error("detector on in sleep");
    level_copy_a: assert property ((up_cnt > 8'h08 && $stable(CONFIG_IN.brownout_level_sel)) [*6]
        |-> BROWNOUT_LEVEL == CONFIG_IN.brownout_level_sel) else $error("level select not copied");
    dip_filter_a: assert property ($rose(BROWNOUT_RESET) |-> $past(low_cnt, 6) >= 8'h28)
        else $error("brown-out trip on short dip");
    trip_hold_a: assert property (BROWNOUT_RESET |-> ##[0:2] CORE_RESET)
        else $error("trip without core reset");
    read_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00) else $error("read data outside slot");
    unmapped_rd_a: assert property (RD && ADDR > STATUS_OFFSET |=> RDATA == 8'h00)
        else $error("unmapped read not zero");
    status_core_a: assert property (RD && ADDR == STATUS_OFFSET ##1 $stable(CORE_RESET)
        |-> RDATA[ST_CORE_RESET_BIT] == CORE_RESET) else $error("status core bit wrong");
    wake_fast_a: assert property (CONFIG_IN.brownout_mode_sel == MODE_ALWAYS_ON && WAKE_REQ && !CORE_RESET
        |=> WAKE_GRANT) else $error("wake delayed in always-on mode");
endmodule
`default_nettype wire

// file: reset_startup_sequencer_tb.sv
// Self-checking bench for the reset and start-up sequencer
`timescale 1ns/1ps
`default_nettype none
module reset_startup_sequencer_tb;
    import reset_startup_pkg::*;
    localparam int TICKS = 4;
    localparam int LO    = (TICKS - 1) * TICK_CYCLES;
    localparam int HI    = (TICKS + 1) * TICK_CYCLES + 12;
    logic              SYS_CLK;
    logic              RST;
    analog_in_type     ANALOG_IN;
    config_type        CONFIG_IN;
    logic              SLEEP;
    logic              WAKE_REQ;
    logic [ADDR_W-1:0] ADDR;
    logic [DATA_W-1:0] WDATA;
    logic              WR;
    logic              RD;
    logic [DATA_W-1:0] RDATA;
    logic              CORE_RESET;
    logic              BROWNOUT_ENABLE;
    logic              BROWNOUT_LEVEL;
    logic              BROWNOUT_RESET;
    logic              WAKE_GRANT;
    logic              sleep_cmd;
    int                errors;
    int                samples_checked;
    reset_startup_sequencer #(.POWERUP_DELAY_TICKS(TICKS)) DUT (.SYS_CLK, .RST, .ANALOG_IN, .CONFIG_IN, .SLEEP,
        .WAKE_REQ, .ADDR, .WDATA, .WR, .RD, .RDATA, .CORE_RESET, .BROWNOUT_ENABLE, .BROWNOUT_LEVEL,
        .BROWNOUT_RESET, .WAKE_GRANT);
    core_model partner (.clk(SYS_CLK), .core_reset(CORE_RESET), .wake_grant(WAKE_GRANT), .sleep_cmd(sleep_cmd),
        .sleep(SLEEP), .wake_req(WAKE_REQ));
    // Compare, count, report
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // Pass cycles, then let the edge settle
    task automatic cyc(input int n);
        repeat (n) @(posedge SYS_CLK);
        #1;
    endtask
    // Register bus write and read
    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge SYS_CLK);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'b1;
        @(posedge SYS_CLK);
        WR <= 1'b0;
    endtask
    task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge SYS_CLK);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge SYS_CLK);
        RD <= 1'b0;
        #1 d = RDATA;
    endtask
    // Bounded wait for a level; n returns the cycles spent; a required wait that runs out ends the run
    task automatic wait_for(ref logic sig, input logic lvl, input int lim, input bit must, output int n);
        n = 0;
        while (sig !== lvl && n < lim) begin
            cyc(1);
            n++;
        end
        if (must && sig !== lvl) begin
            errors++;
            $display("wrong value wait limit expected %0d seen %0d", lvl, sig);
            close_out();
        end
    endtask
    // Power cycle with a new configuration, then wait for core release
    task automatic boot(input logic [1:0] m, input logic dn, input logic rdy, input int lim, output int n);
        ANALOG_IN <= '{1'b0, 1'b0, rdy};
        CONFIG_IN <= '{m, dn, 1'b0};
        cyc(10);
        chk("por hold", 1, CORE_RESET);
        ANALOG_IN.supply_ok <= 1'b1;
        cyc(1);
        wait_for(CORE_RESET, 1'b0, lim, !(m[1] && !rdy), n);
    endtask
    // Supply dip of len cycles; s tells whether a trip was seen
    task automatic dip(input int len, output logic s);
        s = 1'b0;
        ANALOG_IN.below_threshold <= 1'b1;
        for (int i = 0; i < len + 8; i++) begin
            cyc(1);
            if (i == len - 1) ANALOG_IN.below_threshold <= 1'b0;
            s = s | BROWNOUT_RESET;
        end
    endtask
    // Start-up delay, its enable and the ready wait
    task automatic scn_start();
        int n;
        boot(MODE_ALWAYS_ON, 1'b0, 1'b1, 2000, n);
        chk("delay", 1, n >= LO && n <= HI);
        boot(MODE_ALWAYS_ON, 1'b1, 1'b1, 2000, n);
        chk("no delay", 1, n <= 12);
        boot(MODE_ALWAYS_ON, 1'b1, 1'b0, 300, n);
        chk("ready wait", 300, 16'(n));
        ANALOG_IN.detector_ready <= 1'b1;
        wait_for(CORE_RESET, 1'b0, 40, 1'b1, n);
        chk("ready start", 1, n <= 12);
    endtask
    // Register map, refusals and level select
    task automatic scn_regs();
        logic [DATA_W-1:0] d;
        reg_rd(CONTROL_OFFSET, d);
        chk("control", 8'h81, d);
        reg_wr(4'h5, 8'hff);
        reg_rd(4'h5, d);
        chk("unmapped", 8'h00, d);
        reg_rd(STATUS_OFFSET, d);
        chk("status", 8'h00, d);
        CONFIG_IN.brownout_level_sel <= 1'b1;
        cyc(8);
        chk("level", 1, BROWNOUT_LEVEL);
    endtask
    // Dip filter and delay after a trip
    task automatic scn_brown();
        logic s;
        int n;
        boot(MODE_ALWAYS_ON, 1'b0, 1'b1, 2000, n);
        dip(FILTER_CYCLES - 4, s);
        chk("short dip", 0, s);
        dip(FILTER_CYCLES + 20, s);
        chk("long dip", 1, s);
        chk("trip hold", 1, CORE_RESET);
        wait_for(CORE_RESET, 1'b0, 2000, 1'b1, n);
        chk("trip delay", 1, n >= LO - 16 && n <= HI);
    endtask
    // Sleep and wake in always-on and awake-only modes
    task automatic scn_sleep();
        int n;
        sleep_cmd <= 1'b1;
        cyc(10);
        chk("sleep on", 1, BROWNOUT_ENABLE);
        sleep_cmd <= 1'b0;
        wait_for(WAKE_GRANT, 1'b1, 20, 1'b1, n);
        chk("fast wake", 1, n <= 3);
        boot(MODE_AWAKE_ON, 1'b1, 1'b1, 2000, n);
        sleep_cmd <= 1'b1;
        ANALOG_IN.detector_ready <= 1'b0;
        cyc(10);
        chk("sleep off", 0, BROWNOUT_ENABLE);
        sleep_cmd <= 1'b0;
        wait_for(WAKE_GRANT, 1'b1, 20, 1'b0, n);
        chk("wake waits", 20, 16'(n));
        ANALOG_IN.detector_ready <= 1'b1;
        wait_for(WAKE_GRANT, 1'b1, 20, 1'b1, n);
        chk("wake ready", 1, n <= 8);
    endtask
    // Software mode, then off mode overriding software
    task automatic scn_soft();
        logic s;
        int n;
        boot(MODE_SOFTWARE, 1'b1, 1'b0, 2000, n);
        chk("soft start", 1, n <= 12);
        dip(FILTER_CYCLES + 20, s);
        chk("not ready", 0, s);
        reg_wr(CONTROL_OFFSET, 8'h00);
        cyc(3);
        chk("sw off", 0, BROWNOUT_ENABLE);
        reg_wr(CONTROL_OFFSET, 8'h80);
        cyc(3);
        chk("sw on", 1, BROWNOUT_ENABLE);
        ANALOG_IN.detector_ready <= 1'b1;
        cyc(6);
        dip(FILTER_CYCLES + 20, s);
        chk("soft trip", 1, s);
        boot(MODE_OFF, 1'b1, 1'b0, 2000, n);
        chk("off start", 1, n <= 12);
        reg_wr(CONTROL_OFFSET, 8'h80);
        cyc(3);
        chk("off mode", 0, BROWNOUT_ENABLE);
    endtask
    // Verdict and end of run
    task automatic close_out();
        $display("comparisons %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Clock
    initial begin
        SYS_CLK = 1'b0;
        forever #20 SYS_CLK = ~SYS_CLK;
    end
    // Hang guard
    initial begin
        repeat (100000) @(posedge SYS_CLK);
        errors++;
        close_out();
    end
    // Reset, then the scenarios
    initial begin
        errors = 0;
        samples_checked = 0;
        RST = 1'b1;
        ANALOG_IN = '0;
        CONFIG_IN = '0;
        sleep_cmd = 1'b0;
        ADDR = '0;
        WDATA = '0;
        WR = 1'b0;
        RD = 1'b0;
        repeat (12) @(posedge SYS_CLK);
        RST <= 1'b0;
        scn_start();
        scn_regs();
        scn_brown();
        scn_sleep();
        scn_soft();
        close_out();
    end
endmodule
bind reset_startup_sequencer reset_startup_chk #(.POWERUP_DELAY_TICKS(POWERUP_DELAY_TICKS)) u_chk (.SYS_CLK,
    .RST, .ANALOG_IN, .CONFIG_IN, .WAKE_REQ, .ADDR, .RD, .RDATA, .CORE_RESET, .BROWNOUT_ENABLE,
    .BROWNOUT_LEVEL, .BROWNOUT_RESET, .WAKE_GRANT, .SLEEP);
`default_nettype wire
